// [verilog/opaf_pkg.sv]
package opaf_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_BASE    = 8'h08;
  localparam logic [7:0] OFF_INDEX   = 8'h0C;
  localparam logic [7:0] OFF_INSTR_DISPLACEMENT    = 8'h10;
  localparam logic [7:0] OFF_PTR     = 8'h14;
  localparam logic [7:0] OFF_SEG     = 8'h18;
  localparam logic [7:0] OFF_OPADDR  = 8'h1C;
  localparam logic [7:0] OFF_EXEC    = 8'h20;

  // Control register field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MODE_MSB  = 2;
  localparam int CTRL_POST_BIT  = 3;
  localparam int CTRL_IND32_BIT = 4;
  localparam int CTRL_BSEL_LSB  = 5;
  localparam int CTRL_BSEL_MSB  = 6;
  localparam int CTRL_START_BIT = 8;

  // Status register field positions
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_PH1_BIT   = 1;
  localparam int STAT_PH2_BIT   = 2;
  localparam int STAT_HOLD_BIT  = 3;
  localparam int STAT_STATE_LSB = 4;

  // Operand half width and the byte split used by floating immediates
  localparam int HALF_BITS = 16;
  localparam int BYTE_BITS = 8;

  // Addressing modes as software writes them into the control register
  localparam logic [2:0] MODE_RR       = 3'h0;
  localparam logic [2:0] MODE_IMM_HALF = 3'h1;
  localparam logic [2:0] MODE_IMM_FULL = 3'h2;
  localparam logic [2:0] MODE_IMM_FLT  = 3'h3;
  localparam logic [2:0] MODE_DIRECT   = 3'h4;
  localparam logic [2:0] MODE_DIR_IDX  = 3'h5;
  localparam logic [2:0] MODE_DIR_BASE = 3'h6;
  localparam logic [2:0] MODE_INDIRECT = 3'h7;

  // Base register select code of the procedure base (low half reads zero)
  localparam logic [1:0] BSEL_PROC = 2'h0;

  // Reset values
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Pipeline beat sequence of one instruction
  typedef enum logic [2:0] {
    ST_IDLE, ST_S4, ST_S5, ST_S6, ST_P2A, ST_P2B, ST_S7
  } opaf_state_t;

endpackage

// [verilog/opaf_unit.sv]
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps

// What this block does
// - Memory forms: address from registers and displacement, loaded end stage 6, used in 7
// - Extended RR and immediates load the operand itself; no memory reference issued
// - Half-word immediate: value to upper half, lower half cleared
// - Full-word immediate: value sign-extended to 32 bits across both halves
// - Floating immediate: high byte up, low byte down, other bytes zeroed
// - Operand held after stage 6 is read in stage 7, sent to execution
// - Register-to-register: both adders pass the source register unchanged
// - Direct indexed: base plus index, then displacement added
// - Direct with base register: pass base, then add displacement
// - Immediates ignore base adder; displacement adder gives zero or displacement
// - Indirect phase one forms pointer address; first-phase indicator active two stages
// - Assist hold raised after stage 4 of indirect, lasts two beats
// - During the hold phase one forms the pointer address into the operand address register
// - Indirect phase two uses second address; indicator active exactly two beats
// - Selected base register is fetched in stage 5 for the pointer address
// - Base select latched end stage 4, relatched to procedure base after phase one
// - Phase two: base adder adds index to zero, displacement adder adds pointer
// - Pointer low half latched beat one of phase two, loaded low, optionally indexed
// - 32-bit indirection loads pointer upper half; 16-bit leaves upper half alone
// - Base adder passes base or adds index; active-low carry adds one
// - Displacement adder: zero, one, displacement, base output or sum, plus carry
module opaf_unit #(
  parameter int HALF_W = 16
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Pipeline indicators
  output logic                   indirect_first_phase_n,
  output logic                   indirect_second_phase_n,
  output logic                   assist_hold_n,
  // Memory access and execution hand-off in stage 7
  output logic                   mem_req,
  output logic [31:0]            mem_addr,
  output logic                   exec_valid,
  output logic [31:0]            exec_operand
);

  // The register map packs both halves into one bus word, so only 16 fits
  if (HALF_W != opaf_pkg::HALF_BITS) begin : g_bad_width
    $error("opaf_unit: HALF_W must be 16");
  end

  localparam int HB = HALF_W / 2;

  // Bus phase capture
  logic               wr_pend_q;
  logic [7:0]         wr_addr_q;
  logic [31:0]        hrdata_q;

  // Software-loaded operands
  logic [2:0]         mode_q;
  logic               post_q;
  logic               ind32_q;
  logic [1:0]         bsel_req_q;
  logic [HALF_W-1:0]  base_q;
  logic [HALF_W-1:0]  index_q;
  logic [HALF_W-1:0]  instr_displacement_q;
  logic [31:0]        ptr_q;
  logic [HALF_W-1:0]  seg_q;

  // Datapath state
  opaf_pkg::opaf_state_t state_q;
  opaf_pkg::opaf_state_t state_d;
  logic [1:0]         base_sel_q;
  logic [HALF_W-1:0]  instr_displacement_latch_q;
  logic [HALF_W-1:0]  opa_upper_q;
  logic [HALF_W-1:0]  opa_lower_q;
  logic               mem_req_q;
  logic [31:0]        mem_addr_q;
  logic               exec_valid_q;
  logic [31:0]        exec_operand_q;

  // Bus decode: zero-wait slave, every access answered OKAY
  wire bus_take   = hsel & hready & htrans[1];
  wire wr_ctrl    = wr_pend_q & (wr_addr_q == opaf_pkg::OFF_CTRL);
  wire start_req  = wr_ctrl & hwdata[opaf_pkg::CTRL_START_BIT];
  wire idle       = (state_q == opaf_pkg::ST_IDLE);
  wire is_ind     = (mode_q == opaf_pkg::MODE_INDIRECT);
  wire is_mem     = mode_q[2];
  wire phase1     = is_ind & ((state_q == opaf_pkg::ST_S5) | (state_q == opaf_pkg::ST_S6));
  wire phase2     = (state_q == opaf_pkg::ST_P2A) | (state_q == opaf_pkg::ST_P2B);
  wire [31:0] opa = {opa_upper_q, opa_lower_q};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Read mux, sampled in the address phase so hrdata comes from a flop
  wire [31:0] status_word = {25'h0, 3'(state_q), assist_hold_n == 1'b0,
                             phase2, phase1, ~idle};
  wire [31:0] ctrl_word   = {25'h0, bsel_req_q, ind32_q, post_q, mode_q};
  wire [7:0]  rd_off      = haddr[7:0];
  wire [31:0] rd_mux =
      (rd_off == opaf_pkg::OFF_CTRL)   ? ctrl_word :
      (rd_off == opaf_pkg::OFF_STATUS) ? status_word :
      (rd_off == opaf_pkg::OFF_BASE)   ? {16'h0, base_q} :
      (rd_off == opaf_pkg::OFF_INDEX)  ? {16'h0, index_q} :
      (rd_off == opaf_pkg::OFF_INSTR_DISPLACEMENT)   ? {16'h0, instr_displacement_q} :
      (rd_off == opaf_pkg::OFF_PTR)    ? ptr_q :
      (rd_off == opaf_pkg::OFF_SEG)    ? {16'h0, seg_q} :
      (rd_off == opaf_pkg::OFF_OPADDR) ? opa :
      (rd_off == opaf_pkg::OFF_EXEC)   ? exec_operand_q : opaf_pkg::WORD_RST;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= opaf_pkg::WORD_RST;
    end else begin
      wr_pend_q <= bus_take & hwrite;
      wr_addr_q <= haddr[7:0];
      if (bus_take & ~hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // Operand registers; they are locked while an instruction runs so that
  // the datapath never sees a half-updated operand set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q     <= opaf_pkg::MODE_RR;
      post_q     <= 1'b0;
      ind32_q    <= 1'b0;
      bsel_req_q <= opaf_pkg::BSEL_PROC;
      base_q     <= opaf_pkg::HALF_RST;
      index_q    <= opaf_pkg::HALF_RST;
      instr_displacement_q     <= opaf_pkg::HALF_RST;
      ptr_q      <= opaf_pkg::WORD_RST;
      seg_q      <= opaf_pkg::HALF_RST;
    end else if (wr_pend_q & idle) begin
      if (wr_ctrl) begin
        mode_q     <= hwdata[opaf_pkg::CTRL_MODE_MSB:opaf_pkg::CTRL_MODE_LSB];
        post_q     <= hwdata[opaf_pkg::CTRL_POST_BIT];
        ind32_q    <= hwdata[opaf_pkg::CTRL_IND32_BIT];
        bsel_req_q <= hwdata[opaf_pkg::CTRL_BSEL_MSB:opaf_pkg::CTRL_BSEL_LSB];
      end
      if (wr_addr_q == opaf_pkg::OFF_BASE)  base_q  <= hwdata[HALF_W-1:0];
      if (wr_addr_q == opaf_pkg::OFF_INDEX) index_q <= hwdata[HALF_W-1:0];
      if (wr_addr_q == opaf_pkg::OFF_INSTR_DISPLACEMENT)  instr_displacement_q  <= hwdata[HALF_W-1:0];
      if (wr_addr_q == opaf_pkg::OFF_PTR)   ptr_q   <= hwdata;
      if (wr_addr_q == opaf_pkg::OFF_SEG)   seg_q   <= hwdata[HALF_W-1:0];
    end
  end

  // Beat sequencer: one hclk edge ends one pipeline stage
  always_comb begin
    state_d = state_q;
    case (state_q)
      opaf_pkg::ST_IDLE: if (start_req) state_d = opaf_pkg::ST_S4;
      opaf_pkg::ST_S4:   state_d = opaf_pkg::ST_S5;
      opaf_pkg::ST_S5:   state_d = opaf_pkg::ST_S6;
      opaf_pkg::ST_S6:   state_d = is_ind ? opaf_pkg::ST_P2A : opaf_pkg::ST_S7;
      opaf_pkg::ST_P2A:  state_d = opaf_pkg::ST_P2B;
      opaf_pkg::ST_P2B:  state_d = opaf_pkg::ST_S7;
      opaf_pkg::ST_S7:   state_d = opaf_pkg::ST_IDLE;
      default:           state_d = opaf_pkg::ST_IDLE;
    endcase
  end

  // Indicators; the hold spans the two beats after stage 4 of an indirect
  assign indirect_first_phase_n  = ~phase1;
  assign indirect_second_phase_n = ~phase2;
  assign assist_hold_n           = ~phase1;

  // Base register fetch; the procedure base low half always reads zero
  wire [HALF_W-1:0] base_val = (base_sel_q == opaf_pkg::BSEL_PROC) ?
                               opaf_pkg::HALF_RST : base_q;

  // Adder controls per mode and phase
  wire imm_mode      = ~mode_q[2] & (mode_q != opaf_pkg::MODE_RR);
  wire bx_add_select = (mode_q == opaf_pkg::MODE_DIR_IDX) | phase2;
  wire bx_carry_in_n = 1'b1;
  wire d_pass_left   = phase2 ? post_q : ~imm_mode;
  wire d_pass_right  = phase2 | (is_mem | (mode_q == opaf_pkg::MODE_IMM_FULL));
  wire d_carry_in_n  = 1'b1;

  // Base-index adder: pass or add, with active-low carry-in
  wire [HALF_W-1:0] bx_index = bx_add_select ? index_q : opaf_pkg::HALF_RST;
  wire [HALF_W-1:0] base_index_adder =
      HALF_W'(base_val + bx_index + {{(HALF_W-1){1'b0}}, ~bx_carry_in_n});

  // Displacement adder: two transport selects and active-low carry-in
  wire [HALF_W-1:0] instr_displacement_in  = phase2 ? instr_displacement_latch_q : instr_displacement_q;
  wire [HALF_W-1:0] d_left   = d_pass_left ? base_index_adder : opaf_pkg::HALF_RST;
  wire [HALF_W-1:0] d_right  = d_pass_right ? instr_displacement_in : opaf_pkg::HALF_RST;
  wire [HALF_W-1:0] displacement_adder =
      HALF_W'(d_left + d_right + {{(HALF_W-1){1'b0}}, ~d_carry_in_n});

  // Values loaded into the operand address register at the end of stage 6
  wire [HALF_W-1:0] imm_sign  = {HALF_W{instr_displacement_q[HALF_W-1]}};
  wire [HALF_W-1:0] flt_upper = {instr_displacement_q[HALF_W-1:HB], {HB{1'b0}}};
  wire [HALF_W-1:0] flt_lower = {{HB{1'b0}}, instr_displacement_q[HB-1:0]};
  wire [HALF_W-1:0] s6_upper =
      (mode_q == opaf_pkg::MODE_IMM_HALF) ? instr_displacement_q :
      (mode_q == opaf_pkg::MODE_IMM_FULL) ? imm_sign :
      (mode_q == opaf_pkg::MODE_IMM_FLT)  ? flt_upper :
      (mode_q == opaf_pkg::MODE_RR)       ? opaf_pkg::HALF_RST : seg_q;
  wire [HALF_W-1:0] s6_lower =
      (mode_q == opaf_pkg::MODE_IMM_FLT) ? flt_lower : displacement_adder;

  // Sequencer state and base select latching
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= opaf_pkg::ST_IDLE;
      base_sel_q <= opaf_pkg::BSEL_PROC;
    end else begin
      state_q <= state_d;
      if (state_q == opaf_pkg::ST_S4) begin
        base_sel_q <= bsel_req_q;
      end else if ((state_q == opaf_pkg::ST_S6) & is_ind) begin
        base_sel_q <= opaf_pkg::BSEL_PROC;
      end
    end
  end

  // Operand address register halves and pointer latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa_upper_q  <= opaf_pkg::HALF_RST;
      opa_lower_q  <= opaf_pkg::HALF_RST;
      instr_displacement_latch_q <= opaf_pkg::HALF_RST;
    end else begin
      if (state_q == opaf_pkg::ST_S6) begin
        opa_upper_q <= s6_upper;
        opa_lower_q <= s6_lower;
      end
      if (state_q == opaf_pkg::ST_P2A) begin
        instr_displacement_latch_q <= ptr_q[HALF_W-1:0];
      end
      if (state_q == opaf_pkg::ST_P2B) begin
        opa_lower_q <= displacement_adder;
        if (ind32_q) begin
          opa_upper_q <= ptr_q[31:HALF_W];
        end
      end
    end
  end

  // Stage 7: memory forms issue the access, the rest forward the operand
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req_q      <= 1'b0;
      mem_addr_q     <= opaf_pkg::WORD_RST;
      exec_valid_q   <= 1'b0;
      exec_operand_q <= opaf_pkg::WORD_RST;
    end else begin
      mem_req_q    <= (state_q == opaf_pkg::ST_S7) & is_mem;
      exec_valid_q <= (state_q == opaf_pkg::ST_S7) & ~is_mem;
      if ((state_q == opaf_pkg::ST_S7) & is_mem) begin
        mem_addr_q <= opa;
      end
      if ((state_q == opaf_pkg::ST_S7) & ~is_mem) begin
        exec_operand_q <= opa;
      end
    end
  end

  assign mem_req      = mem_req_q;
  assign mem_addr     = mem_addr_q;
  assign exec_valid   = exec_valid_q;
  assign exec_operand = exec_operand_q;

  // Checks on the sequencing and datapath
  a_hold_two_beats: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(assist_hold_n) |->
      $past(state_q) == opaf_pkg::ST_S4 ##1 !assist_hold_n ##1 assist_hold_n)
    else $error("assist hold not exactly two beats after stage 4");

  a_first_phase_span: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(indirect_first_phase_n) |-> state_q == opaf_pkg::ST_S5 ##1
      (state_q == opaf_pkg::ST_S6 && !indirect_first_phase_n) ##1 indirect_first_phase_n)
    else $error("first phase not active through stages 5 and 6");

  a_second_phase_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(indirect_first_phase_n) |-> !indirect_second_phase_n [*2] ##1 indirect_second_phase_n)
    else $error("second phase not exactly two beats after phase one");

  a_half_imm_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S6 && mode_q == opaf_pkg::MODE_IMM_HALF) |=>
      opa_upper_q == $past(instr_displacement_q) && opa_lower_q == 16'h0000)
    else $error("half immediate load wrong");

  a_full_imm_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S6 && mode_q == opaf_pkg::MODE_IMM_FULL) |=>
      $signed(opa) == $signed($past(instr_displacement_q)))
    else $error("full immediate not sign extended");

  a_float_imm_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S6 && mode_q == opaf_pkg::MODE_IMM_FLT) |=>
      opa == {$past(instr_displacement_q[15:8]), 16'h0000, $past(instr_displacement_q[7:0])})
    else $error("floating immediate bytes misplaced");

  a_rr_pass_through: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S6 && mode_q == opaf_pkg::MODE_RR) |=>
      opa_lower_q == $past(base_val))
    else $error("register operand altered by adders");

  a_ext_no_mem: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S7 && !is_mem) |=>
      exec_valid && !mem_req && exec_operand == $past(opa))
    else $error("extended operand not forwarded or memory touched");

  a_proc_base_forced: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S6 && is_ind) |=> base_sel_q == opaf_pkg::BSEL_PROC)
    else $error("procedure base not selected after phase one");

  a_ind16_upper_kept: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_P2B && !ind32_q) |=> $stable(opa_upper_q))
    else $error("upper half loaded on 16-bit indirection");

  a_opa_stable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q != opaf_pkg::ST_S6 && state_q != opaf_pkg::ST_P2B) |=> $stable(opa))
    else $error("operand address register changed off a load beat");

  a_mem_issue_addr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S7 && is_mem) |=>
      mem_req && !exec_valid && mem_addr == $past(opa))
    else $error("memory access not issued with the formed address");

  a_dir_idx_sum: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_S6 && mode_q == opaf_pkg::MODE_DIR_IDX) |=>
      opa_lower_q == 16'($past(base_val) + $past(index_q) + $past(instr_displacement_q)))
    else $error("direct indexed offset wrong");

  a_half_instr_displacement_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q != opaf_pkg::ST_IDLE && mode_q == opaf_pkg::MODE_IMM_HALF) |->
      displacement_adder == 16'h0000)
    else $error("displacement adder not zero for half immediate");

  a_index_through_bx: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_P2B) |->
      base_index_adder == index_q)
    else $error("base adder not passing index in phase two");

  a_ptr_low_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_P2B) |=>
      opa_lower_q == 16'($past(ptr_q[15:0]) + ($past(post_q) ? $past(index_q) : 16'h0000)))
    else $error("pointer low half not loaded into lower half");

  a_ind32_upper_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == opaf_pkg::ST_P2B && ind32_q) |=>
      opa_upper_q == $past(ptr_q[31:16]))
    else $error("pointer upper half not loaded on 32-bit indirection");

endmodule

// [dv/opaf_host_model.sv]
`timescale 1ns/10ps

// AHB-Lite master standing in for the pipeline control side
module opaf_host_model (
  // Clock
  input  wire logic        hclk,
  // AHB-Lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // Idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'hA5A5_5A5A;
  end

  // One single word transfer; unqualified lines are inverted so stale values never match
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr  <= ~addr;
    hwdata <= wr ? wdata : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rdata = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// [dv/operand_address_formation_bench.sv]
`timescale 1ns/10ps

module operand_address_formation_bench;
  // Operand sources; sums chosen to wrap past 16 bits
  localparam logic [15:0] VB = 16'h7001;
  localparam logic [15:0] VX = 16'h8003;
  localparam logic [15:0] VD = 16'h9A5C;
  localparam logic [15:0] VS = 16'h5E2B;
  localparam logic [31:0] VP = 32'hC3D2_F00F;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        ph1_n;
  logic        ph2_n;
  logic        hold_n;
  logic        mem_req;
  logic [31:0] mem_addr;
  logic        exec_valid;
  logic [31:0] exec_operand;
  int          fails;
  int          checks_done;
  int          c_mem;
  int          c_exe;
  int          c_ph1;
  int          c_ph2;
  int          c_hold;
  longint      t0;

  opaf_host_model opaf_host_model_inst (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));

  opaf_unit opaf_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .indirect_first_phase_n(ph1_n),
    .indirect_second_phase_n(ph2_n), .assist_hold_n(hold_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .exec_valid(exec_valid), .exec_operand(exec_operand));

  // Clock at 100 ns
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Cycle counts of pulses and indicators, compared as differences per operation
  always @(posedge hclk) begin
    c_mem  += (mem_req === 1'b1);
    c_exe  += (exec_valid === 1'b1);
    c_ph1  += (ph1_n === 1'b0);
    c_ph2  += (ph2_n === 1'b0);
    c_hold += (hold_n === 1'b0);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    opaf_host_model_inst.xfer(1'b1, {24'h0, a}, d, unused);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    opaf_host_model_inst.xfer(1'b0, {24'h0, a}, 32'h0, d);
  endtask

  function automatic logic [31:0] ctl(logic [2:0] m, logic post, logic i32, logic [1:0] bs);
    return (32'h1 << opaf_pkg::CTRL_START_BIT) | (32'(bs) << opaf_pkg::CTRL_BSEL_LSB) |
           (32'(i32) << opaf_pkg::CTRL_IND32_BIT) | (32'(post) << opaf_pkg::CTRL_POST_BIT) |
           32'(m);
  endfunction

  // Start one operation, optionally poke a write while busy, and judge the outcome
  task automatic run_op(input logic [31:0] c, input logic [31:0] exp, input logic is_mem,
                        input int lat, input int ind, input logic poke);
    int          m0;
    int          e0;
    int          f0;
    int          s0;
    int          h0;
    int          n;
    logic [31:0] keep;
    logic [31:0] r;
    m0 = c_mem;
    e0 = c_exe;
    f0 = c_ph1;
    s0 = c_ph2;
    h0 = c_hold;
    keep = is_mem ? exec_operand : mem_addr;
    wr(opaf_pkg::OFF_CTRL, c);
    t0 = $time;
    if (poke) begin
      wr(opaf_pkg::OFF_INSTR_DISPLACEMENT, 32'h0000_1111);
    end
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (mem_req !== 1'b1 && exec_valid !== 1'b1 && n < 20);
    check(32'(($time - 1 - t0) / 100), 32'(lat));
    @(posedge hclk);
    #1;
    check(32'(c_mem - m0), {31'h0, is_mem});
    check(32'(c_exe - e0), {31'h0, ~is_mem});
    check(32'(c_ph1 - f0), 32'(ind));
    check(32'(c_hold - h0), 32'(ind));
    check(32'(c_ph2 - s0), 32'(ind));
    check(is_mem ? mem_addr : exec_operand, exp);
    check(is_mem ? exec_operand : mem_addr, keep);
    rd(opaf_pkg::OFF_OPADDR, r);
    check(r, exp);
    rd(opaf_pkg::OFF_STATUS, r);
    check(r, 32'h0);
  endtask

  // Reset state, read-only and unmapped places, operand source loading
  task automatic t_regs;
    logic [31:0] r;
    check({25'h0, hreadyout, hresp, ph1_n, ph2_n, hold_n, mem_req, exec_valid},
          32'h5C);
    check(mem_addr | exec_operand, 32'h0);
    wr(opaf_pkg::OFF_OPADDR, 32'hFFFF_FFFF);
    rd(opaf_pkg::OFF_OPADDR, r);
    check(r, 32'h0);
    rd(8'h40, r);
    check(r, 32'h0);
    wr(opaf_pkg::OFF_BASE, {16'h0, VB});
    wr(opaf_pkg::OFF_INDEX, {16'h0, VX});
    wr(opaf_pkg::OFF_INSTR_DISPLACEMENT, {16'h0, VD});
    wr(opaf_pkg::OFF_PTR, VP);
    wr(opaf_pkg::OFF_SEG, {16'h0, VS});
    rd(opaf_pkg::OFF_BASE, r);
    check(r, {16'h0, VB});
  endtask

  // Memory address forms, one with a refused write while busy
  task automatic t_direct;
    logic [31:0] r;
    run_op(ctl(opaf_pkg::MODE_DIRECT, 1'b0, 1'b0, 2'h0), {VS, VD},
           1'b1, 4, 0, 1'b0);
    run_op(ctl(opaf_pkg::MODE_DIR_IDX, 1'b0, 1'b0, 2'h0), {VS, VX + VD},
           1'b1, 4, 0, 1'b0);
    run_op(ctl(opaf_pkg::MODE_DIR_BASE, 1'b0, 1'b0, 2'h1), {VS, VB + VD},
           1'b1, 4, 0, 1'b1);
    rd(opaf_pkg::OFF_INSTR_DISPLACEMENT, r);
    check(r, {16'h0, VD});
  endtask

  // Operands carried to execution with no memory reference
  task automatic t_immediates;
    logic [15:0] d;
    logic [31:0] r;
    run_op(ctl(opaf_pkg::MODE_RR, 1'b0, 1'b0, 2'h1), {16'h0, VB},
           1'b0, 4, 0, 1'b0);
    run_op(ctl(opaf_pkg::MODE_IMM_HALF, 1'b0, 1'b0, 2'h1), {VD, 16'h0},
           1'b0, 4, 0, 1'b0);
    run_op(ctl(opaf_pkg::MODE_IMM_FLT, 1'b0, 1'b0, 2'h1), {VD[15:8], 16'h0, VD[7:0]}, 1'b0,
           4, 0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? VD : 16'h7FFF;
      wr(opaf_pkg::OFF_INSTR_DISPLACEMENT, {16'h0, d});
      run_op(ctl(opaf_pkg::MODE_IMM_FULL, 1'b0, 1'b0, 2'h1), {{16{d[15]}}, d},
             1'b0, 4, 0, 1'b0);
    end
    rd(opaf_pkg::OFF_EXEC, r);
    check(r, {16'h0, 16'h7FFF});
    wr(opaf_pkg::OFF_INSTR_DISPLACEMENT, {16'h0, VD});
  endtask

  // Two-phase indirection for every post-index and width combination
  task automatic t_indirect;
    logic        post;
    logic        i32;
    logic [31:0] exp;
    for (int i = 0; i < 4; i++) begin
      post = i[0];
      i32  = i[1];
      exp  = {i32 ? VP[31:16] : VS, VP[15:0] + (post ? VX : 16'h0)};
      run_op(ctl(opaf_pkg::MODE_INDIRECT, post, i32, 2'h1), exp, 1'b1, 6, 2,
             1'b0);
    end
  endtask

  // Main sequence
  initial begin
    hresetn     = 1'b0;
    fails       = 0;
    checks_done = 0;
    c_mem       = 0;
    c_exe       = 0;
    c_ph1       = 0;
    c_ph2       = 0;
    c_hold      = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    t_regs();
    t_direct();
    t_immediates();
    t_indirect();
    end_sim();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    fails++;
    end_sim();
  end
endmodule
